// ===== dv/core_regs_sva.sv
// Checker for the core pointer and status registers
`timescale 1ns/1ns
`default_nettype none
`include "core_regs_defs.vh"
module core_regs_sva (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Datapath
	input wire logic        alu_go,
	input wire logic [2:0]  alu_op,
	input wire logic [7:0]  alu_operand,
	input wire logic [7:0]  second_result,
	input wire logic        second_result_we,
	// Stack and pointer
	input wire logic        push_go,
	input wire logic [7:0]  push_data,
	input wire logic        pop_go,
	input wire logic [7:0]  stack_addr,
	input wire logic [7:0]  stack_wdata,
	input wire logic        stack_wr_en,
	input wire logic        stack_rd_en,
	input wire logic        ptr_inc_go,
	input wire logic [15:0] indirect_pointer,
	// Core state
	input wire logic [7:0]  accumulator,
	input wire logic [7:0]  program_status_word,
	input wire logic [7:0]  stack_top_pointer,
	input wire logic [7:0]  bank_base
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_RST: assert property ($rose(nrst) |-> stack_top_pointer == 8'h07 && accumulator == 8'h00)
		else $error("reset values wrong");
	AST_PAR: assert property (program_status_word[0] == ^accumulator)
		else $error("parity flag wrong");
	AST_BANK: assert property (bank_base == {3'b000, program_status_word[4:3], 3'b000})
		else $error("bank base wrong");
	AST_PTR: assert property (ptr_inc_go |=> indirect_pointer == $past(indirect_pointer) + 16'h0001)
		else $error("pointer step wrong");
	AST_PUSH: assert property (push_go |=> stack_wr_en && stack_addr == stack_top_pointer
		&& stack_top_pointer == $past(stack_top_pointer) + 8'h01 && stack_wdata == $past(push_data))
		else $error("push wrong");
	AST_POP: assert property (pop_go && !push_go |=> stack_rd_en && stack_addr == $past(stack_top_pointer)
		&& stack_top_pointer == $past(stack_top_pointer) - 8'h01)
		else $error("pop wrong");
	AST_ADD: assert property (alu_go && alu_op == `OP_ADD |=>
		{program_status_word[7], accumulator} == $past(accumulator) + $past(alu_operand)
		&& program_status_word[6] == ($past(accumulator[3:0]) + $past(alu_operand[3:0]) > 5'h0F)
		&& program_status_word[2] == ($past(accumulator[7]) == $past(alu_operand[7])
		&& accumulator[7] != $past(accumulator[7])))
		else $error("add flags wrong");
	AST_MUL: assert property (alu_go && alu_op == `OP_MUL |=> second_result_we
		&& {second_result, accumulator} == $past(accumulator) * $past(alu_operand)
		&& program_status_word[2] == (second_result != 8'h00) && program_status_word[7:6] == 2'b00)
		else $error("multiply wrong");
	AST_DIV0: assert property (alu_go && alu_op == `OP_DIV && alu_operand == 8'h00 |=>
		program_status_word[2] && accumulator == 8'h00 && second_result == 8'h00)
		else $error("zero divide wrong");
endmodule // core_regs_sva
bind core_pointer_status_regs core_regs_sva u_sva (.mclk, .nrst, .alu_go, .alu_op, .alu_operand,
	.second_result, .second_result_we, .push_go, .push_data, .pop_go, .stack_addr, .stack_wdata,
	.stack_wr_en, .stack_rd_en, .ptr_inc_go, .indirect_pointer, .accumulator,
	.program_status_word, .stack_top_pointer, .bank_base);
`default_nettype wire

// ===== dv/stack_ram_model.sv
// Stack memory model on the far side of the push and pop strobes
`timescale 1ns/1ns
`default_nettype none
module stack_ram_model (
	// Clock
	input  wire logic       mclk,
	// Stack strobes from the core
	input  wire logic [7:0] stack_addr,
	input  wire logic [7:0] stack_wdata,
	input  wire logic       stack_wr_en,
	input  wire logic       stack_rd_en,
	// Popped byte
	output var  logic [7:0] pop_byte
);
	logic [7:0] mem [256];
	always @(posedge mclk) begin
		if (stack_wr_en)
			mem[stack_addr] <= stack_wdata;
		// Idle cycles toggle so stale data never looks valid
		pop_byte <= stack_rd_en ? mem[stack_addr] : ~pop_byte;
	end
endmodule // stack_ram_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the core pointer and status registers
`timescale 1ns/1ns
`default_nettype none
`include "core_regs_defs.vh"
module testbench;
	logic        mclk, nrst, sfr_wr, sfr_rd, bit_wr, bit_wdata, bit_rd;
	logic        alu_go, push_go, pop_go, ptr_inc_go, sfr_rvalid, sfr_hit;
	logic        bit_rdata, bit_rvalid, second_result_we, stack_wr_en, stack_rd_en;
	logic [2:0]  alu_op, op;
	logic [7:0]  sfr_addr, sfr_wdata, bit_addr, alu_operand, push_data, sfr_rdata;
	logic [7:0]  second_result, stack_addr, stack_wdata, accumulator, bank_base;
	logic [7:0]  program_status_word, stack_top_pointer, a, b, p, v, pop_byte;
	logic [15:0] indirect_pointer;
	logic [15:0] q [$];
	logic [18:0] r;
	logic [7:0]  adr [4] = '{8'h81, 8'h82, 8'h83, 8'hE0};
	int          err_total, check_count, i;

	core_pointer_status_regs u_dut (.mclk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_rdata, .sfr_rvalid, .sfr_hit, .bit_addr, .bit_wr, .bit_wdata, .bit_rd, .bit_rdata,
		.bit_rvalid, .alu_go, .alu_op, .alu_operand, .second_result, .second_result_we,
		.push_go, .push_data, .pop_go, .stack_addr, .stack_wdata, .stack_wr_en, .stack_rd_en,
		.ptr_inc_go, .indirect_pointer, .accumulator, .program_status_word,
		.stack_top_pointer, .bank_base);
	stack_ram_model u_ram (.mclk, .stack_addr, .stack_wdata, .stack_wr_en, .stack_rd_en,
		.pop_byte(pop_byte));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ----------------------------------------
	// Drivers and scoreboard
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	// One request edge; strobes drop at the edge that takes them
	task automatic take();
		@(posedge mclk);
		{sfr_wr, sfr_rd, bit_wr, bit_rd, alu_go, push_go, pop_go, ptr_inc_go} <= 8'h00;
	endtask
	task automatic settle();
		repeat (2) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= ad;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		take();
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] d, input logic h);
		@(posedge mclk);
		sfr_addr <= ad;
		sfr_rd <= 1'b1;
		q.push_back({7'h00, h, d});
		take();
	endtask
	task automatic bacc(input logic [7:0] ad, input logic d, input logic rdn);
		@(posedge mclk);
		bit_addr <= ad;
		bit_wdata <= d;
		bit_wr <= !rdn;
		bit_rd <= rdn;
		if (rdn)
			q.push_back({15'h0000, d});
		take();
	endtask
	always @(posedge mclk) begin
		if (sfr_rvalid === 1'b1 && q.size() > 0)
			chk("byte read", q.pop_front(), {7'h00, sfr_hit, sfr_rdata});
		if (bit_rvalid === 1'b1 && q.size() > 0)
			chk("bit read", q.pop_front(), {15'h0000, bit_rdata});
	end
	function automatic logic [18:0] ref_alu(input logic [2:0] o, input logic [7:0] x, y, f);
		logic [8:0]  s;
		logic [4:0]  n;
		logic [15:0] m;
		logic        c;
		c = (o == `OP_ADDC || o == `OP_SUBB) && f[7];
		s = {1'b0, x} + y + c;
		n = {1'b0, x[3:0]} + y[3:0] + c;
		if (o == `OP_SUBB) begin
			s = {1'b0, x} - y - c;
			n = {1'b0, x[3:0]} - y[3:0] - c;
		end
		m = x * y;
		case (o)
			`OP_ADD, `OP_ADDC: ref_alu = {s[7:0], 8'h00, s[8], n[4], ~(x[7] ^ y[7]) & (x[7] ^ s[7])};
			`OP_SUBB: ref_alu = {s[7:0], 8'h00, s[8], n[4], (x[7] ^ y[7]) & (x[7] ^ s[7])};
			`OP_MUL: ref_alu = {m[7:0], m[15:8], 2'b00, |m[15:8]};
			`OP_DIV: ref_alu = (y == 8'h00) ? 19'h00001 : {x / y, x % y, 3'b000};
			default: ref_alu = {y, 8'h00, f[7], f[6], f[2]};
		endcase
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{sfr_wr, sfr_rd, bit_wr, bit_rd, alu_go, push_go, pop_go, ptr_inc_go} = 8'h00;
		{sfr_addr, sfr_wdata, bit_addr, alu_operand, push_data, bit_wdata, alu_op} = 44'h0;
		nrst = 1'b0;
		err_total = 0;
		check_count = 0;
		v = 8'($urandom(32'h2558));
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		rd(8'h81, 8'h07, 1'b1);
		for (i = 1; i < 4; i++)
			rd(adr[i], 8'h00, 1'b1);
		rd(8'hD0, 8'h00, 1'b1);
		// A register owned by another block: mapped in the device, not answered here
		rd(8'h87, 8'h00, 1'b0);
		@(posedge mclk);
		push_data <= 8'hA5;
		push_go <= 1'b1;
		take();
		settle();
		chk("first push", 16'h00A5, {8'h00, u_ram.mem[8'h08]});
		@(posedge mclk);
		pop_go <= 1'b1;
		take();
		settle();
		chk("pop", 16'h07A5, {stack_top_pointer, pop_byte});
		wr(8'h81, 8'hFF);
		@(posedge mclk);
		push_data <= 8'h3C;
		push_go <= 1'b1;
		take();
		settle();
		chk("wrap", 16'h003C, {stack_top_pointer, u_ram.mem[8'h00]});
		for (i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(adr[i], v);
			rd(adr[i], v, 1'b1);
		end
		wr(8'h83, 8'h12);
		wr(8'h82, 8'hFF);
		@(posedge mclk);
		ptr_inc_go <= 1'b1;
		take();
		settle();
		chk("pointer", 16'h1300, indirect_pointer);
		wr(8'h83, v);
		wr(8'h82, 8'hFF);
		@(posedge mclk);
		ptr_inc_go <= 1'b1;
		take();
		settle();
		chk("pointer", {v + 8'h01, 8'h00}, indirect_pointer);
		for (i = 0; i < 4; i++) begin
			wr(8'hD0, 8'(i << 3));
			settle();
			chk("bank", 16'(i * 8), {8'h00, bank_base});
		end
		wr(8'hE0, 8'h00);
		bacc(8'hE3, 1'b1, 1'b0);
		rd(8'hE0, 8'h08, 1'b1);
		bacc(8'hD0, 1'b0, 1'b0);
		rd(8'hD0, 8'h19, 1'b1);
		bacc(8'h8B, 1'b1, 1'b0);
		bacc(8'h8B, 1'b0, 1'b1);
		bacc(8'hD5, 1'b1, 1'b0);
		bacc(8'hD5, 1'b1, 1'b1);
		bacc(8'hD4, 1'b1, 1'b1);
		for (i = 0; i < 32; i++) begin
			a = 8'($urandom);
			b = (i == 12) ? 8'h00 : 8'($urandom);
			p = 8'($urandom);
			op = 3'(i % 8);
			wr(8'hE0, a);
			wr(8'hD0, p);
			r = ref_alu(op, a, b, p);
			@(posedge mclk);
			alu_op <= op;
			alu_operand <= b;
			alu_go <= 1'b1;
			take();
			rd(8'hE0, r[18:11], 1'b1);
			rd(8'hD0, {r[2:1], p[5:3], r[0], p[1], ^r[18:11]}, 1'b1);
			if (op == `OP_MUL || op == `OP_DIV)
				chk("second", {8'h00, r[10:3]}, {8'h00, second_result});
		end
		// Mid-run reset must restore the same values
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd(8'h81, 8'h07, 1'b1);
		rd(8'hE0, 8'h00, 1'b1);
		settle();
		chk("pending", 16'h0000, 16'(q.size()));
		results();
	end

	initial begin
		#400000;
		err_total++;
		results();
	end
endmodule // testbench
`default_nettype wire

// ===== rtl/arith_flag_unit.v
// Arithmetic result and flag evaluation for the accumulator datapath
`timescale 1ns/1ns
`default_nettype none
`include "core_regs_defs.vh"

module arith_flag_unit (
	// Operation
	input  wire [2:0] op,
	input  wire [7:0] opa,
	input  wire [7:0] opb,
	input  wire       cin,
	// Results
	output reg  [7:0] res_lo,
	output reg  [7:0] res_hi,
	output reg        res_hi_we,
	output reg        carry_out,
	output reg        nibble_out,
	output reg        overflow_out,
	output reg        flags_we
);

	reg  [8:0]  sum9;
	reg  [4:0]  nib5;
	reg  [15:0] prod;
	reg         cbit;

	always @* begin
		sum9      = 9'h000;
		nib5      = 5'h00;
		prod      = 16'h0000;
		cbit      = (op == `OP_ADD) ? 1'b0 : cin;
		res_lo    = opb;
		res_hi    = 8'h00;
		res_hi_we = 1'b0;
		carry_out    = 1'b0;
		nibble_out   = 1'b0;
		overflow_out = 1'b0;
		flags_we  = 1'b1;
		case (op)
			`OP_ADD, `OP_ADDC: begin
				sum9   = {1'b0, opa} + {1'b0, opb} + {8'h00, cbit};
				nib5   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cbit};
				res_lo = sum9[7:0];
				carry_out  = sum9[8];
				nibble_out = nib5[4];
				// Signed overflow: like signs in, other sign out
				overflow_out = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
			end
			`OP_SUBB: begin
				sum9   = {1'b0, opa} - {1'b0, opb} - {8'h00, cbit};
				nib5   = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cbit};
				res_lo = sum9[7:0];
				carry_out    = sum9[8];
				nibble_out   = nib5[4];
				overflow_out = (opa[7] != opb[7]) && (sum9[7] != opa[7]);
			end
			`OP_MUL: begin
				prod         = opa * opb;
				res_lo       = prod[7:0];
				res_hi       = prod[15:8];
				res_hi_we    = 1'b1;
				overflow_out = |prod[15:8];
			end
			`OP_DIV: begin
				// Zero divisor leaves both bytes at zero rather than unknown
				res_hi_we = 1'b1;
				if (opb == 8'h00) begin
					res_lo       = 8'h00;
					overflow_out = 1'b1;
				end else begin
					res_lo = opa / opb;
					res_hi = opa % opb;
				end
			end
			default: begin
				flags_we = 1'b0;
			end
		endcase
	end

endmodule // arith_flag_unit
`default_nettype wire

// ===== rtl/core_pointer_status_regs.v
// Accumulator, data pointer, stack pointer and status word of the core
`timescale 1ns/1ns
`default_nettype none
`include "core_regs_defs.vh"

// Summary of operation
// - Pointer is high byte register over low byte register, sixteen bits.
// - That pointer addresses indirect flash and external space RAM accesses.
// - Push increments stack pointer first, then writes byte at new location.
// - Reset loads stack pointer with 07 so first push lands at 08.
// - Carry bit 7 set by add carry or subtract borrow, else cleared by the five arithmetic operations.
// - Nibble carry bit 6 set by carry or borrow out of lower nibble.
// - Bits 5 and 1 are user flags written only by software.
// - Bits 4 to 3 select one of four eight-byte working register banks.
// - Overflow bit 2 set on signed overflow of add, addc, subb.
// - Overflow set when multiply product exceeds 255.
// - Overflow set when divide sees a zero divisor.
// - Otherwise those five operations clear the overflow flag.
// - Bit 0 is read-only parity, one when accumulator has odd ones.
// - Accumulator is eight-bit read-write bit-addressable, zero after reset.
// - Only addresses ending 0 or 8 are bit-addressable; others byte only.
module core_pointer_status_regs (
	// Clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// Byte access to the register space
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_rd,
	output wire [7:0]  sfr_rdata,
	output wire        sfr_rvalid,
	output wire        sfr_hit,
	// Bit access to the register space
	input  wire [7:0]  bit_addr,
	input  wire        bit_wr,
	input  wire        bit_wdata,
	input  wire        bit_rd,
	output wire        bit_rdata,
	output wire        bit_rvalid,
	// Arithmetic datapath
	input  wire        alu_go,
	input  wire [2:0]  alu_op,
	input  wire [7:0]  alu_operand,
	output wire [7:0]  second_result,
	output wire        second_result_we,
	// Stack operations
	input  wire        push_go,
	input  wire [7:0]  push_data,
	input  wire        pop_go,
	output wire [7:0]  stack_addr,
	output wire [7:0]  stack_wdata,
	output wire        stack_wr_en,
	output wire        stack_rd_en,
	// Pointer operations
	input  wire        ptr_inc_go,
	output wire [15:0] indirect_pointer,
	// Core state
	output wire [7:0]  accumulator,
	output wire [7:0]  program_status_word,
	output wire [7:0]  stack_top_pointer,
	output wire [7:0]  bank_base
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [7:0] accumulator_reg;
	reg  [7:0] accumulator_next;
	reg  [7:0] stack_ptr_reg;
	reg  [7:0] stack_ptr_next;
	reg  [7:0] ptr_low_byte_reg;
	reg  [7:0] ptr_low_byte_next;
	reg  [7:0] ptr_high_byte_reg;
	reg  [7:0] ptr_high_byte_next;
	reg        carry_flag_reg;
	reg        carry_flag_next;
	reg        nibble_carry_flag_reg;
	reg        nibble_carry_flag_next;
	reg        user_flag_a_reg;
	reg        user_flag_a_next;
	reg        bank_select_hi_reg;
	reg        bank_select_hi_next;
	reg        bank_select_lo_reg;
	reg        bank_select_lo_next;
	reg        overflow_flag_reg;
	reg        overflow_flag_next;
	reg        user_flag_b_reg;
	reg        user_flag_b_next;
	reg        parity_reg;
	reg  [7:0] rdata_reg;
	reg  [7:0] rdata_next;
	reg        rvalid_reg;
	reg        hit_reg;
	reg        hit_next;
	reg        bit_rdata_reg;
	reg        bit_rvalid_reg;
	reg  [7:0] second_reg;
	reg        second_we_reg;
	reg  [7:0] stack_addr_reg;
	reg  [7:0] stack_wdata_reg;
	reg        stack_wr_reg;
	reg        stack_rd_reg;

	// ----------------------------------------
	// Arithmetic unit
	// ----------------------------------------
	wire [7:0] alu_lo;
	wire [7:0] alu_hi;
	wire       alu_hi_we;
	wire       alu_carry;
	wire       alu_nibble;
	wire       alu_overflow;
	wire       alu_flags_we;

	arith_flag_unit u_alu (
		.op           (alu_op),
		.opa          (accumulator_reg),
		.opb          (alu_operand),
		.cin          (carry_flag_reg),
		.res_lo       (alu_lo),
		.res_hi       (alu_hi),
		.res_hi_we    (alu_hi_we),
		.carry_out    (alu_carry),
		.nibble_out   (alu_nibble),
		.overflow_out (alu_overflow),
		.flags_we     (alu_flags_we)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire       wr_accum   = sfr_wr && (sfr_addr == `ADDR_ACCUM);
	wire       wr_status  = sfr_wr && (sfr_addr == `ADDR_STATUS);
	wire       wr_stack   = sfr_wr && (sfr_addr == `ADDR_STACK_PTR);
	wire       wr_ptr_lo  = sfr_wr && (sfr_addr == `ADDR_PTR_LOW);
	wire       wr_ptr_hi  = sfr_wr && (sfr_addr == `ADDR_PTR_HIGH);
	// Bit space always lands on bytes ending in 0 or 8; stack and pointer bytes never reached
	wire [7:0] bit_byte   = {bit_addr[7:3], 3'h0};
	wire [2:0] bit_sel    = bit_addr[2:0];
	wire       bwr_accum  = bit_wr && (bit_byte == `ADDR_ACCUM);
	wire       bwr_status = bit_wr && (bit_byte == `ADDR_STATUS);

	wire [7:0] status_now = {carry_flag_reg, nibble_carry_flag_reg, user_flag_a_reg,
		bank_select_hi_reg, bank_select_lo_reg, overflow_flag_reg,
		user_flag_b_reg, parity_reg};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	reg [7:0] status_sw;

	always @* begin
		status_sw        = status_now;
		accumulator_next = accumulator_reg;
		// Software byte write, then bit write; later hardware update wins
		if (wr_accum) begin
			accumulator_next = sfr_wdata;
		end
		if (bwr_accum) begin
			accumulator_next[bit_sel] = bit_wdata;
		end
		if (wr_status) begin
			status_sw = sfr_wdata;
		end
		if (bwr_status) begin
			status_sw[bit_sel] = bit_wdata;
		end
		carry_flag_next        = status_sw[`BIT_CARRY];
		nibble_carry_flag_next = status_sw[`BIT_NIBBLE_CARRY];
		user_flag_a_next       = status_sw[`BIT_USER_A];
		bank_select_hi_next    = status_sw[`BIT_BANK_HI];
		bank_select_lo_next    = status_sw[`BIT_BANK_LO];
		overflow_flag_next     = status_sw[`BIT_OVERFLOW];
		user_flag_b_next       = status_sw[`BIT_USER_B];
		// Hardware result overrides a same-cycle software write to the accumulator and the flags it updates; that write is lost
		if (alu_go) begin
			accumulator_next = alu_lo;
			if (alu_flags_we) begin
				carry_flag_next        = alu_carry;
				nibble_carry_flag_next = alu_nibble;
				overflow_flag_next     = alu_overflow;
			end
		end
	end

	always @* begin
		stack_ptr_next = stack_ptr_reg;
		if (wr_stack) begin
			stack_ptr_next = sfr_wdata;
		end
		// Push takes priority over pop and over a software write
		if (push_go) begin
			stack_ptr_next = stack_ptr_reg + `STACK_STEP;
		end else if (pop_go) begin
			stack_ptr_next = stack_ptr_reg - `STACK_STEP;
		end
	end

	always @* begin
		ptr_low_byte_next  = ptr_low_byte_reg;
		ptr_high_byte_next = ptr_high_byte_reg;
		if (wr_ptr_lo) begin
			ptr_low_byte_next = sfr_wdata;
		end
		if (wr_ptr_hi) begin
			ptr_high_byte_next = sfr_wdata;
		end
		if (ptr_inc_go) begin
			{ptr_high_byte_next, ptr_low_byte_next} =
				{ptr_high_byte_reg, ptr_low_byte_reg} + `PTR_STEP;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		hit_next = 1'b1;
		case (sfr_addr)
			`ADDR_ACCUM:     rdata_next = accumulator_reg;
			`ADDR_STATUS:    rdata_next = status_now;
			`ADDR_STACK_PTR: rdata_next = stack_ptr_reg;
			`ADDR_PTR_LOW:   rdata_next = ptr_low_byte_reg;
			`ADDR_PTR_HIGH:  rdata_next = ptr_high_byte_reg;
			default: begin
				// Unmapped reads return zero and a low hit
				rdata_next = 8'h00;
				hit_next   = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Core registers
	// ----------------------------------------
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			accumulator_reg       <= `RST_ACCUM;
			stack_ptr_reg         <= `RST_STACK_PTR;
			ptr_low_byte_reg      <= `RST_PTR_LOW;
			ptr_high_byte_reg     <= `RST_PTR_HIGH;
			carry_flag_reg        <= 1'b0;
			nibble_carry_flag_reg <= 1'b0;
			user_flag_a_reg       <= 1'b0;
			bank_select_hi_reg    <= 1'b0;
			bank_select_lo_reg    <= 1'b0;
			overflow_flag_reg     <= 1'b0;
			user_flag_b_reg       <= 1'b0;
			parity_reg            <= 1'b0;
		end else begin
			accumulator_reg       <= accumulator_next;
			stack_ptr_reg         <= stack_ptr_next;
			ptr_low_byte_reg      <= ptr_low_byte_next;
			ptr_high_byte_reg     <= ptr_high_byte_next;
			carry_flag_reg        <= carry_flag_next;
			nibble_carry_flag_reg <= nibble_carry_flag_next;
			user_flag_a_reg       <= user_flag_a_next;
			bank_select_hi_reg    <= bank_select_hi_next;
			bank_select_lo_reg    <= bank_select_lo_next;
			overflow_flag_reg     <= overflow_flag_next;
			user_flag_b_reg       <= user_flag_b_next;
			// Tracks the accumulator's next value; written status bit 0 is dropped
			parity_reg            <= ^accumulator_next;
		end
	end

	// ----------------------------------------
	// Read answers
	// ----------------------------------------
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg      <= 8'h00;
			rvalid_reg     <= 1'b0;
			hit_reg        <= 1'b0;
			bit_rdata_reg  <= 1'b0;
			bit_rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg     <= sfr_rd;
			bit_rvalid_reg <= bit_rd;
			if (sfr_rd) begin
				rdata_reg <= rdata_next;
				hit_reg   <= hit_next;
			end
			if (bit_rd) begin
				if (bit_byte == `ADDR_ACCUM) begin
					bit_rdata_reg <= accumulator_reg[bit_sel];
				end else if (bit_byte == `ADDR_STATUS) begin
					bit_rdata_reg <= status_now[bit_sel];
				end else begin
					bit_rdata_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Stack and second result strobes
	// ----------------------------------------
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stack_addr_reg  <= 8'h00;
			stack_wdata_reg <= 8'h00;
			stack_wr_reg    <= 1'b0;
			stack_rd_reg    <= 1'b0;
			second_reg      <= 8'h00;
			second_we_reg   <= 1'b0;
		end else begin
			stack_wr_reg  <= push_go;
			stack_rd_reg  <= pop_go && !push_go;
			second_we_reg <= alu_go && alu_hi_we;
			if (push_go) begin
				// Write goes to the incremented pointer, one cycle after the request
				stack_addr_reg  <= stack_ptr_reg + `STACK_STEP;
				stack_wdata_reg <= push_data;
			end else if (pop_go) begin
				// Pop reads the current top before the decrement takes effect
				stack_addr_reg <= stack_ptr_reg;
			end
			if (alu_go && alu_hi_we) begin
				second_reg <= alu_hi;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sfr_rdata           = rdata_reg;
	assign sfr_rvalid          = rvalid_reg;
	assign sfr_hit             = hit_reg;
	assign bit_rdata           = bit_rdata_reg;
	assign bit_rvalid          = bit_rvalid_reg;
	assign second_result       = second_reg;
	assign second_result_we    = second_we_reg;
	assign stack_addr          = stack_addr_reg;
	assign stack_wdata         = stack_wdata_reg;
	assign stack_wr_en         = stack_wr_reg;
	assign stack_rd_en         = stack_rd_reg;
	assign indirect_pointer    = {ptr_high_byte_reg, ptr_low_byte_reg};
	assign accumulator         = accumulator_reg;
	assign program_status_word = status_now;
	assign stack_top_pointer   = stack_ptr_reg;
	// Bank base is bank number times eight
	assign bank_base = {3'h0, bank_select_hi_reg, bank_select_lo_reg,
		{`BANK_SIZE_LOG2{1'b0}}};

endmodule // core_pointer_status_regs
`default_nettype wire

// ===== rtl/core_regs_defs.vh
// Constants for the core pointer and status registers
`ifndef CORE_REGS_DEFS_VH
`define CORE_REGS_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_STACK_PTR   8'h81
`define ADDR_PTR_LOW     8'h82
`define ADDR_PTR_HIGH    8'h83
`define ADDR_STATUS      8'hD0
`define ADDR_ACCUM       8'hE0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_STACK_PTR    8'h07
`define RST_PTR_LOW      8'h00
`define RST_PTR_HIGH     8'h00
`define RST_STATUS       8'h00
`define RST_ACCUM        8'h00

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define BIT_CARRY        7
`define BIT_NIBBLE_CARRY 6
`define BIT_USER_A       5
`define BIT_BANK_HI      4
`define BIT_BANK_LO      3
`define BIT_OVERFLOW     2
`define BIT_USER_B       1
`define BIT_PARITY       0

// ----------------------------------------
// Datapath operation codes
// ----------------------------------------
`define OP_ADD           3'h0
`define OP_ADDC          3'h1
`define OP_SUBB          3'h2
`define OP_MUL           3'h3
`define OP_DIV           3'h4
`define OP_LOAD          3'h5

// ----------------------------------------
// Misc
// ----------------------------------------
`define STACK_STEP       8'h01
`define PTR_STEP         16'h0001
`define BANK_SIZE_LOG2   3

`endif
